// ---- lvr_pkg.sv ----
// constants for the low voltage reset filter
// assumes one 250 MHz clock, sys_clk, taken as the cpu cycle
// Function
// RQ1: monitor runs straight after reset release
// RQ2: power enable gates all monitoring and resets
// RQ3: reset after nine consecutive low cycles
// RQ4: hold reset until above rising level once
// RQ5: stop mode monitoring needs both enables
// RQ6: flag sets after 32 to 40 crystal cycles
// RQ7: flag clears above rising, holds between levels
// RQ8: any system reset clears the flag
// RQ9: supply reset also pulls reset pin low
// RQ10: no interrupt output exists at all
// RQ11: software polls flag with reset disabled
// RQ12: wait mode keeps monitor, reset wakes it
// RQ13: in stop, trip skips filter, resets directly
// RQ14: stop without stop enable idles monitor
// RQ15: flag is read-only bit 7 of status
// RQ16: comparator synchronised before both counters
// RQ17: crystal clock runs at crystal frequency
package lvr_pkg;
  // register map, plain port with byte address
  localparam logic [15:0] LVR_STATUS_ADDR = 16'hfe0f;
  localparam int LVR_FLAG_BIT = 7;
  localparam logic [7:0] LVR_RDATA_RESET = 8'h00;
  localparam logic LVR_FLAG_RESET = 1'b0;
  // filter lengths
  localparam int LVR_FALL_CYCLES = 9;
  localparam int LVR_RISE_CYCLES = 1;
  localparam int LVR_FLAG_MIN_EDGES = 32;
  localparam int LVR_FLAG_MAX_EDGES = 40;
  // chosen set point inside the window, margin for sync delay
  localparam int LVR_FLAG_SET_EDGES = 34;
  // monitor state
  typedef enum logic [0:0] {
    LVR_ST_WATCH,
    LVR_ST_RESET
  } lvr_state_t;
endpackage : lvr_pkg

// ---- lvr_sync.sv ----
// three stage synchroniser with agreement filter
// assumes inputs asynchronous to clk; output changes only when
// stages two and three agree
`timescale 1ns/100ps
module lvr_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_r; // first stage, read only by s2
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] agree; // bits where stages two and three match

  assign agree = ~(s2_r ^ s3_r);

  // shift chain
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // accepted level, holds while stages disagree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= (s2_r & agree) | (q & ~agree);
    end
  end
endmodule : lvr_sync

// ---- lvr_count.sv ----
// saturating run counter: hit rises once level has stood n steps
// assumes level and step are on the same clock
`timescale 1ns/100ps
module lvr_count #(
  parameter int N = 9,
  parameter int CW = 6
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic level,
  input wire logic step,
  output logic hit
);
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  localparam logic [CW-1:0] LIMIT = CW'(N);

  // any drop of the level restarts the run
  always_comb begin
    cnt_nxt = cnt_r;
    if (clear || !level) begin
      cnt_nxt = '0;
    end else if (step && cnt_r != LIMIT) begin
      cnt_nxt = cnt_r + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign hit = (cnt_r == LIMIT);
endmodule : lvr_count

// ---- lvr_top.sv ----
// supply monitor digital side: filter, forced reset, status flag
// assumes comparator and crystal clock arrive asynchronously,
// configuration and mode inputs come from logic on sys_clk
//
// The plain strobed port is this design's own decision.
`timescale 1ns/100ps
module lvr_top (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic below_falling_trip, // comparator, async
  input wire logic above_rising_trip, // comparator, async
  input wire logic crystal_clock, // sampled, not a clock domain
  input wire logic monitor_power_enable,
  input wire logic low_voltage_reset_enable,
  input wire logic stop_mode_monitor_enable,
  input wire logic stop_mode, // cpu clocks halted
  input wire logic wait_mode,
  input wire logic system_reset_in, // any system reset, level
  input wire logic [15:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [7:0] bus_rdata,
  output logic supply_reset, // system reset request and wake
  output logic reset_pin_out, // open drain, always low value
  output logic reset_pin_oe, // high while pulling pin low
  output logic low_voltage_flag
);
  // reset release through two flops
  logic rst_meta_r;
  logic rst_sync_n_r;
  // synchronised analog and crystal levels
  logic [2:0] sync_q;
  logic below_s;
  logic above_s;
  logic xtal_s;
  logic xtal_d_r; // previous crystal level for edge detect
  logic xtal_rise;
  // monitor activity
  logic active_r;
  logic active_nxt;
  // filter outputs
  logic fall_hit;
  logic flag_hit;
  // state
  lvr_pkg::lvr_state_t state_r;
  lvr_pkg::lvr_state_t state_nxt;
  logic trip;

  // asynchronous assert, synchronous release
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_r <= 1'b0;
      rst_sync_n_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_n_r <= rst_meta_r;
    end
  end

  // comparator and crystal into the cpu clock domain
  lvr_sync #(
    .W(3)
  ) u_sync (
    .clk(sys_clk),
    .rst_n(rst_sync_n_r),
    .d({crystal_clock, above_rising_trip, below_falling_trip}),
    .q(sync_q)
  ); // RQ16

  assign below_s = sync_q[0];
  assign above_s = sync_q[1];
  assign xtal_s = sync_q[2];

  // crystal rising edges time the flag at crystal frequency
  always_ff @(posedge sys_clk or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      xtal_d_r <= 1'b0;
    end else begin
      xtal_d_r <= xtal_s;
    end
  end

  assign xtal_rise = xtal_s & ~xtal_d_r; // RQ17

  // monitor on when powered; in stop also needs stop enable;
  // wait mode keeps it on
  always_comb begin
    active_nxt = monitor_power_enable; // RQ2 RQ12
    if (stop_mode) begin
      active_nxt = monitor_power_enable & stop_mode_monitor_enable; // RQ5 RQ14
    end
  end

  // starts at one so monitoring needs no software action
  always_ff @(posedge sys_clk or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      active_r <= 1'b1; // RQ1
    end else begin
      active_r <= active_nxt;
    end
  end

  // nine consecutive cpu cycles at or below the falling level
  lvr_count #(
    .N(lvr_pkg::LVR_FALL_CYCLES),
    .CW(4)
  ) u_fall (
    .clk(sys_clk),
    .rst_n(rst_sync_n_r),
    .clear(~active_r),
    .level(below_s),
    .step(1'b1),
    .hit(fall_hit)
  ); // RQ3

  // crystal edges below the falling level for the flag
  lvr_count #(
    .N(lvr_pkg::LVR_FLAG_SET_EDGES),
    .CW(6)
  ) u_flag (
    .clk(sys_clk),
    .rst_n(rst_sync_n_r),
    .clear(~active_r),
    .level(below_s),
    .step(xtal_rise),
    .hit(flag_hit)
  ); // RQ6

  // stop mode has no cpu cycles to count: synchronised trip resets directly
  always_comb begin
    trip = fall_hit; // RQ3
    if (stop_mode) begin
      trip = below_s; // RQ13
    end
  end

  // watch / hold-in-reset sequence
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      lvr_pkg::LVR_ST_WATCH: begin
        // reset only with power and reset enable both set
        if (active_r && low_voltage_reset_enable && trip) begin
          state_nxt = lvr_pkg::LVR_ST_RESET; // RQ3 RQ11
        end
      end
      lvr_pkg::LVR_ST_RESET: begin
        // one cycle above the rising level releases
        if (above_s || !active_r) begin
          state_nxt = lvr_pkg::LVR_ST_WATCH; // RQ4 RQ2
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      state_r <= lvr_pkg::LVR_ST_WATCH;
    end else begin
      state_r <= state_nxt;
    end
  end

  // reset request and pin drive from the next state, so both
  // change in the same cycle; reset also ends wait and stop
  always_ff @(posedge sys_clk or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      supply_reset <= 1'b0;
      reset_pin_oe <= 1'b0;
      reset_pin_out <= 1'b0;
    end else begin
      supply_reset <= (state_nxt == lvr_pkg::LVR_ST_RESET); // RQ12 RQ13
      reset_pin_oe <= (state_nxt == lvr_pkg::LVR_ST_RESET); // RQ9
      reset_pin_out <= 1'b0; // open drain only ever pulls low
    end
  end

  // status flag; system reset wins over any set
  always_ff @(posedge sys_clk or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      low_voltage_flag <= lvr_pkg::LVR_FLAG_RESET;
    end else if (system_reset_in || supply_reset) begin
      low_voltage_flag <= 1'b0; // RQ8
    end else if (!active_r) begin
      low_voltage_flag <= low_voltage_flag; // RQ2
    end else if (above_s) begin
      low_voltage_flag <= 1'b0; // RQ7
    end else if (flag_hit) begin
      low_voltage_flag <= 1'b1; // RQ6
    end
  end

  // read port; writes are ignored, the flag is read-only.
  // no interrupt output is provided.
  always_ff @(posedge sys_clk or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      bus_rdata <= lvr_pkg::LVR_RDATA_RESET;
    end else begin
      bus_rdata <= lvr_pkg::LVR_RDATA_RESET;
      if (bus_rd && bus_addr == lvr_pkg::LVR_STATUS_ADDR) begin
        bus_rdata[lvr_pkg::LVR_FLAG_BIT] <= low_voltage_flag; // RQ15 RQ10
      end
    end
  end
endmodule : lvr_top

// ---- lvr_top_chk.sv ----
// port checker for lvr_top
// assumes one sys_clk domain, rst_n async active low
`timescale 1ns/100ps
module lvr_top_chk (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic below_falling_trip,
  input wire logic above_rising_trip,
  input wire logic crystal_clock,
  input wire logic monitor_power_enable,
  input wire logic low_voltage_reset_enable,
  input wire logic stop_mode,
  input wire logic system_reset_in,
  input wire logic [15:0] bus_addr,
  input wire logic bus_rd,
  input wire logic [7:0] bus_rdata,
  input wire logic supply_reset,
  input wire logic reset_pin_out,
  input wire logic reset_pin_oe,
  input wire logic low_voltage_flag
);
  int low_cnt; // raw low run, sync lag makes it an upper bound
  int xtal_cnt; // crystal edges during the raw low run
  logic xtal_d; // last crystal sample
  // run counters on the raw comparator
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      low_cnt <= 0;
      xtal_cnt <= 0;
      xtal_d <= 1'b0;
    end else begin
      xtal_d <= crystal_clock;
      low_cnt <= below_falling_trip ? low_cnt + 1 : 0;
      if (!below_falling_trip) begin
        xtal_cnt <= 0;
      end else if (crystal_clock && !xtal_d) begin
        xtal_cnt <= xtal_cnt + 1;
      end
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // low long enough to pass the synchroniser, monitor armed
  sequence still_low;
    (below_falling_trip && monitor_power_enable &&
     low_voltage_reset_enable && !stop_mode)[*4];
  endsequence
  pin_follow_a: assert property (
    reset_pin_oe == supply_reset && !reset_pin_out)
    else $error("reset pin differs from reset");
  power_gate_a: assert property (
    !monitor_power_enable[*3] |=> !$rose(supply_reset))
    else $error("reset with monitor off");
  rst_gate_a: assert property (
    !low_voltage_reset_enable[*3] |=> !$rose(supply_reset))
    else $error("reset with reset disabled");
  run_filter_a: assert property (
    $rose(supply_reset) && !stop_mode && !$past(stop_mode) &&
    !$past(stop_mode, 2) |-> low_cnt >= 9)
    else $error("reset before nine low cycles");
  reset_hold_a: assert property (
    still_low ##0 supply_reset |=> supply_reset)
    else $error("reset dropped while low");
  flag_clear_a: assert property (
    (above_rising_trip && monitor_power_enable && !stop_mode)[*6]
    |=> !low_voltage_flag)
    else $error("flag set while above");
  flag_sysrst_a: assert property (
    system_reset_in |=> !low_voltage_flag)
    else $error("flag survived reset");
  flag_early_a: assert property (
    $rose(low_voltage_flag) |-> xtal_cnt >= lvr_pkg::LVR_FLAG_MIN_EDGES)
    else $error("flag set too early");
  rd_flag_a: assert property (
    $past(bus_rd) && $past(bus_addr) == lvr_pkg::LVR_STATUS_ADDR
    |-> bus_rdata == {$past(low_voltage_flag), 7'h00})
    else $error("status read wrong");
  rd_idle_a: assert property (
    !bus_rd |=> bus_rdata == 8'h00)
    else $error("read data without read");
endmodule : lvr_top_chk
bind lvr_top lvr_top_chk i_lvr_top_chk (.*);

// ---- lvr_supply_model.sv ----
// comparator and crystal model for the filter bench
// assumes lvl from bench: 0 above, 1 between, 2 below
`timescale 1ns/100ps
module lvr_supply_model (
  input wire logic [1:0] lvl,
  output logic below_falling_trip,
  output logic above_rising_trip,
  output logic crystal_clock
);
  // never both trips at once
  assign below_falling_trip = (lvl == 2'h2);
  assign above_rising_trip = (lvl == 2'h0);
  // free running crystal, unrelated to sys_clk
  initial crystal_clock = 1'b0;
  always #20.3 crystal_clock = ~crystal_clock;
endmodule : lvr_supply_model

// ---- lvr_top_tb.sv ----
// self-checking bench for lvr_top
// assumes 250 MHz sys_clk and the supply model
`timescale 1ns/100ps
module lvr_top_tb;
  logic sys_clk = 1'b0, rst_n = 1'b0;
  logic [1:0] lvl = 2'h0; // supply level to model
  logic pwr = 1'b1, rsten = 1'b1, stpen = 1'b1, stp = 1'b0;
  logic wt = 1'b0, srst = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00, rdata;
  logic below, above, xclk, sup, pin_o, pin_oe, flag;
  int err_count = 0, cmp_count = 0, cyc = 0;
  localparam logic [15:0] SA = lvr_pkg::LVR_STATUS_ADDR;
  always #2 sys_clk = ~sys_clk;
  lvr_supply_model i_lvr_supply_model (.lvl(lvl),
    .below_falling_trip(below), .above_rising_trip(above),
    .crystal_clock(xclk));
  lvr_top i_lvr_top (.sys_clk(sys_clk), .rst_n(rst_n),
    .below_falling_trip(below), .above_rising_trip(above),
    .crystal_clock(xclk), .monitor_power_enable(pwr),
    .low_voltage_reset_enable(rsten),
    .stop_mode_monitor_enable(stpen), .stop_mode(stp),
    .wait_mode(wt), .system_reset_in(srst), .bus_addr(addr),
    .bus_wdata(wdata), .bus_wr(wr), .bus_rd(rd), .bus_rdata(rdata),
    .supply_reset(sup), .reset_pin_out(pin_o),
    .reset_pin_oe(pin_oe), .low_voltage_flag(flag));
  task automatic chk(input string n, input logic [7:0] e, g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick
  task automatic lv(input logic [1:0] v);
    @(posedge sys_clk);
    lvl <= v;
  endtask : lv
  // read strobe one cycle, data in the next cycle only
  task automatic rdc(input logic [15:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1 chk("bus_rdata", e, rdata);
  endtask : rdc
  // sticky watch: no reset pulse at all over n cycles
  task automatic nores(input int n);
    logic s;
    s = 1'b0;
    repeat (n) begin
      @(posedge sys_clk);
      #1 s = s | sup;
    end
    chk("supply_reset", 8'h00, {7'h0, s});
  endtask : nores
  task automatic wres(input logic e, input int n);
    int i;
    i = 0;
    while (sup !== e && i < n) begin
      @(posedge sys_clk);
      #1 i++;
    end
    chk("supply_reset", {7'h0, e}, {7'h0, sup});
  endtask : wres
  task automatic t_filter();
    lv(2'h2);
    tick(5);
    lv(2'h0);
    nores(20);
    lv(2'h2);
    wres(1'b1, 20);
    chk("reset_pin", 8'h01, {7'h0, pin_oe & ~pin_o});
    lv(2'h1);
    tick(10);
    chk("supply_reset", 8'h01, {7'h0, sup});
    lv(2'h0);
    wres(1'b0, 8);
    $display("t_filter done");
  endtask : t_filter
  task automatic t_poll();
    @(posedge sys_clk);
    rsten <= 1'b0;
    lvl <= 2'h2;
    nores(250);
    chk("flag", 8'h00, {7'h0, flag});
    nores(210);
    chk("flag", 8'h01, {7'h0, flag});
    rdc(SA, 8'h80);
    @(posedge sys_clk);
    wr <= 1'b1;
    addr <= SA;
    @(posedge sys_clk);
    wr <= 1'b0;
    rdc(SA, 8'h80);
    rdc(16'h0000, 8'h00);
    lv(2'h1);
    tick(20);
    chk("flag", 8'h01, {7'h0, flag});
    @(posedge sys_clk);
    srst <= 1'b1;
    @(posedge sys_clk);
    srst <= 1'b0;
    tick(1);
    chk("flag", 8'h00, {7'h0, flag});
    lv(2'h0);
    $display("t_poll done");
  endtask : t_poll
  task automatic t_power();
    @(posedge sys_clk);
    pwr <= 1'b0;
    rsten <= 1'b1;
    lvl <= 2'h2;
    nores(480);
    chk("flag", 8'h00, {7'h0, flag});
    @(posedge sys_clk);
    pwr <= 1'b1;
    lvl <= 2'h0;
    $display("t_power done");
  endtask : t_power
  task automatic t_modes();
    @(posedge sys_clk);
    stp <= 1'b1;
    lvl <= 2'h2;
    wres(1'b1, 8);
    lv(2'h0);
    wres(1'b0, 8);
    @(posedge sys_clk);
    stpen <= 1'b0;
    lvl <= 2'h2;
    nores(30);
    lv(2'h0);
    tick(6);
    @(posedge sys_clk);
    stp <= 1'b0;
    wt <= 1'b1;
    lvl <= 2'h2;
    wres(1'b1, 20);
    lv(2'h0);
    wres(1'b0, 8);
    $display("t_modes done");
  endtask : t_modes
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : wrap_up
  // hang guard, run needs about 1100 cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 4000) begin
      err_count++;
      wrap_up();
    end
  end
  initial begin
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    tick(3);
    rdc(SA, 8'h00);
    t_filter();
    t_poll();
    t_power();
    t_modes();
    wrap_up();
  end
endmodule : lvr_top_tb
